// [mwsd_pkg.sv]
// mwsd_pkg: constants for the wait-entry and shortcut decoder
// assumes 16-bit code words and a 32-bit apb register window
package mwsd_pkg;
    // instruction word fields
    localparam int          MWSD_OPC_HI      = 15;
    localparam int          MWSD_OPC_LO      = 14;
    localparam logic [1:0]  MWSD_OPC_CWER     = 2'h3;
    localparam logic [1:0]  MWSD_OPC_OUTSC    = 2'h2;
    localparam logic [1:0]  MWSD_OUTSC_TAIL   = 2'h3;
    localparam logic [13:0] MWSD_OPC_CURSC    = 14'h0d5e;
    localparam int          MWSD_OFS_LO      = 9;
    localparam int          MWSD_OFS_W       = 5;
    localparam int          MWSD_ROWSEL_LO   = 6;
    localparam int          MWSD_ROWSEL_W    = 3;
    localparam int          MWSD_COND_W      = 6;
    localparam int          MWSD_RT1_LO      = 10;
    localparam int          MWSD_RT2_LO      = 6;
    localparam int          MWSD_RT3_LO      = 2;
    localparam int          MWSD_RT_W        = 4;
    localparam int          MWSD_CSEL_W      = 2;
    // wait table and drivers
    localparam int          MWSD_ROWS        = 5;
    localparam logic [2:0]  MWSD_ROW_LAST     = 3'h4;
    localparam int          MWSD_NHS         = 5;
    localparam int          MWSD_NLS         = 7;
    localparam int          MWSD_NDRV        = 12;
    localparam logic [3:0]  MWSD_RT_UNDEF     = 4'hc;
    localparam int          MWSD_NCUR        = 6;
    // reset shortcut maps, indexed by core: ch1 uc0, ch1 uc1, ch2 uc0, ch2 uc1
    localparam logic [1:0]  MWSD_DEF_CUR [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    localparam logic [3:0]  MWSD_DEF_RT1 [4] = '{4'h0, 4'h1, 4'h2, 4'h3};
    localparam logic [3:0]  MWSD_DEF_RT2 [4] = '{4'h5, 4'h6, 4'h7, 4'h8};
    localparam logic [3:0]  MWSD_DEF_RT3 [4] = '{4'h9, 4'ha, 4'hb, 4'h4};
    // apb map
    localparam logic [11:0] MWSD_A_CTRL      = 12'h000;
    localparam logic [11:0] MWSD_A_SHORTCUT  = 12'h004;
    localparam logic [11:0] MWSD_A_STATUS    = 12'h008;
    localparam logic [11:0] MWSD_A_ROW0      = 12'h010;
    localparam logic [11:0] MWSD_A_ROWSTEP   = 12'h004;
    localparam logic        MWSD_CTRL_RST    = 1'h1;
    localparam int          MWSD_SC_RT1_LO   = 4;
    localparam int          MWSD_SC_RT2_LO   = 8;
    localparam int          MWSD_SC_RT3_LO   = 12;
    localparam int          MWSD_ROW_DEST_LO = 16;
    localparam int          MWSD_ROW_VLD_BIT = 31;
    localparam int          MWSD_ST_ROW_LO   = 1;
    localparam int          MWSD_ST_BAD_BIT  = 4;

    typedef enum logic [1:0] {
        MWSD_IDLE,
        MWSD_WAITING,
        MWSD_RESUMED
    } mwsd_state_t;
endpackage : mwsd_pkg

// [mwsd_wait_table.sv]
// mwsd_wait_table: the five wait-table rows, each {valid, dest, cond}
// assumes the writer checks the row number; all rows leave flops
`timescale 1ns/1ns
module mwsd_wait_table #(
    parameter int ROWS  = 5,
    parameter int ROW_W = 17
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  wr_en,
    input  wire logic [2:0]            wr_row,
    input  wire logic [ROW_W-1:0]      wr_data,
    output logic      [ROWS*ROW_W-1:0] rows
);
    for (genvar i = 0; i < ROWS; i++) begin : g_row
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rows[i*ROW_W +: ROW_W] <= '0;
            end else if (wr_en && wr_row == 3'(i)) begin
                rows[i*ROW_W +: ROW_W] <= wr_data;
            end
        end
    end
endmodule : mwsd_wait_table

// [mwsd_decoder.sv]
// mwsd_decoder: decodes the relative wait-entry, current-shortcut and
// output-shortcut instructions, evaluates the wait table and routes gates
// assumes the fetch unit presents one word per cycle with its code address
// Notes on behaviour
// - relative entry: 11, offset, row, condition
// - codes pick flags, terminal counts, start
// - codes pick shortcut vds and source feedback
// - codes pick alu done and boost voltage
// - codes pick six current feedbacks high/low
// - last two codes test own current
// - row select 000..100 names rows one-five
// - current shortcut picks block, core default
// - selector 00..11 picks blocks 1,2,3,4l
// - three logical outputs routed to gates
// - output routes reset to per-core defaults
// - output shortcut word: 10, three selectors, 11
// - selector codes drivers; 1100 means undefined
// - current shortcut: fixed word, two-bit operand
// - true enabled row resumes at its dest
// - dest is word address plus signed offset
`timescale 1ns/1ns
module mwsd_decoder
    import mwsd_pkg::*;
#(
    parameter int CORE_ID = 0,
    parameter int ADDR_W  = 10
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [11:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 instr_valid,
    input  wire logic [15:0]          instr_word,
    input  wire logic [ADDR_W-1:0]    instr_addr,
    input  wire logic                 wait_active,
    input  wire logic [MWSD_ROWS-1:0] wait_row_enable,
    output logic                      jump_taken,
    output logic      [ADDR_W-1:0]    jump_target,
    output logic      [2:0]           jump_row,
    input  wire logic [15:0]          flags,
    input  wire logic [3:0]           terminal_count,
    input  wire logic                 start_level,
    input  wire logic                 alu_done,
    input  wire logic                 boost_voltage_level,
    input  wire logic [MWSD_NCUR-1:0] current_fb,
    input  wire logic [MWSD_NDRV-1:0] gate_vds_fb,
    input  wire logic [MWSD_NDRV-1:0] gate_src_fb,
    input  wire logic [2:0]           drive_logical,
    output logic      [MWSD_NHS-1:0]  high_side_gate_pin,
    output logic      [MWSD_NLS-1:0]  low_side_gate_pin,
    output logic      [1:0]           measure_block_select,
    output logic      [3:0]           output_route_first,
    output logic      [3:0]           output_route_second,
    output logic      [3:0]           output_route_third
);
    localparam int ROW_W = 1 + ADDR_W + MWSD_COND_W;

    // written over apb further down, read here by the decode
    logic decode_enable;

    // instruction decode
    wire accept     = instr_valid && decode_enable;
    wire is_cwer    = instr_word[MWSD_OPC_HI:MWSD_OPC_LO] == MWSD_OPC_CWER;
    wire is_outsc   = instr_word[MWSD_OPC_HI:MWSD_OPC_LO] == MWSD_OPC_OUTSC
                      && instr_word[1:0] == MWSD_OUTSC_TAIL;
    wire is_cursc   = instr_word[15:MWSD_CSEL_W] == MWSD_OPC_CURSC;
    wire [MWSD_OFS_W-1:0]    ofs     = instr_word[MWSD_OFS_LO +: MWSD_OFS_W];
    wire [MWSD_ROWSEL_W-1:0] row_sel = instr_word[MWSD_ROWSEL_LO +: MWSD_ROWSEL_W];
    wire row_ok     = row_sel <= MWSD_ROW_LAST;
    wire row_wr     = accept && is_cwer && row_ok;
    wire bad_row    = accept && is_cwer && !row_ok;
    // two's complement offset, sign extended to the code address width
    wire [ADDR_W-1:0] next_dest = instr_addr
                      + {{(ADDR_W-MWSD_OFS_W){ofs[MWSD_OFS_W-1]}}, ofs};
    wire [ROW_W-1:0]  row_data  = {1'b1, next_dest, instr_word[MWSD_COND_W-1:0]};

    logic [MWSD_ROWS*ROW_W-1:0] rows;
    mwsd_wait_table #(
        .ROWS  (MWSD_ROWS),
        .ROW_W (ROW_W)
    ) u_table (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (row_wr),
        .wr_row  (row_sel),
        .wr_data (row_data),
        .rows    (rows)
    );

    // shortcut registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measure_block_select <= MWSD_DEF_CUR[CORE_ID];
            output_route_first   <= MWSD_DEF_RT1[CORE_ID];
            output_route_second  <= MWSD_DEF_RT2[CORE_ID];
            output_route_third   <= MWSD_DEF_RT3[CORE_ID];
        end else begin
            if (accept && is_cursc) begin
                measure_block_select <= instr_word[MWSD_CSEL_W-1:0];
            end
            if (accept && is_outsc) begin
                output_route_first  <= instr_word[MWSD_RT1_LO +: MWSD_RT_W];
                output_route_second <= instr_word[MWSD_RT2_LO +: MWSD_RT_W];
                output_route_third  <= instr_word[MWSD_RT3_LO +: MWSD_RT_W];
            end
        end
    end

    // shortcut feedback and gate routing; codes past ls7 drive nothing
    wire [MWSD_RT_W-1:0] route [3];
    assign route[0] = output_route_first;
    assign route[1] = output_route_second;
    assign route[2] = output_route_third;
    logic [2:0]              sc_vds;
    logic [2:0]              sc_src;
    logic [MWSD_NDRV-1:0]    next_gate;
    for (genvar k = 0; k < 3; k++) begin : g_sc
        wire valid_rt = route[k] < MWSD_RT_UNDEF;
        assign sc_vds[k] = valid_rt && gate_vds_fb[route[k]];
        assign sc_src[k] = valid_rt && gate_src_fb[route[k]];
    end
    for (genvar p = 0; p < MWSD_NDRV; p++) begin : g_drv
        assign next_gate[p] = (route[0] == 4'(p) && drive_logical[0])
                            | (route[1] == 4'(p) && drive_logical[1])
                            | (route[2] == 4'(p) && drive_logical[2]);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {low_side_gate_pin, high_side_gate_pin} <= '0;
        end else begin
            {low_side_gate_pin, high_side_gate_pin} <= next_gate;
        end
    end

    // condition vector, indexed directly by the 6-bit code
    wire own_cur = current_fb[measure_block_select];
    wire [63:0] cond_vec = {
        ~own_cur, own_cur,
        ~current_fb, current_fb,
        ~boost_voltage_level, boost_voltage_level, alu_done,
        sc_vds, ~sc_src, ~sc_vds,
        start_level, ~start_level, terminal_count, flags, ~flags
    };

    logic [MWSD_ROWS-1:0] row_hit;
    for (genvar i = 0; i < MWSD_ROWS; i++) begin : g_hit
        wire [ROW_W-1:0] r = rows[i*ROW_W +: ROW_W];
        assign row_hit[i] = r[ROW_W-1] && wait_row_enable[i]
                            && cond_vec[r[MWSD_COND_W-1:0]];
    end
    // lowest row wins when several conditions hold at once
    logic [2:0] hit_idx;
    always_comb begin
        hit_idx = '0;
        for (int i = MWSD_ROWS - 1; i >= 0; i--) begin
            if (row_hit[i]) begin
                hit_idx = 3'(i);
            end
        end
    end
    wire [ADDR_W-1:0] hit_dest =
        rows[int'(hit_idx)*ROW_W + MWSD_COND_W +: ADDR_W];

    mwsd_state_t state;
    mwsd_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            MWSD_IDLE:    if (wait_active) next_state = MWSD_WAITING;
            MWSD_WAITING: begin
                if (!wait_active) next_state = MWSD_IDLE;
                else if (|row_hit) next_state = MWSD_RESUMED;
            end
            MWSD_RESUMED: if (!wait_active) next_state = MWSD_IDLE;
            default:      next_state = MWSD_IDLE;
        endcase
    end
    wire fire = state == MWSD_WAITING && wait_active && |row_hit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= MWSD_IDLE;
            jump_taken  <= 1'b0;
            jump_target <= '0;
            jump_row    <= '0;
        end else begin
            state      <= next_state;
            jump_taken <= fire;
            if (fire) begin
                jump_target <= hit_dest;
                jump_row    <= hit_idx;
            end
        end
    end

    // apb slave: zero wait states, answer prepared in the setup cycle
    logic bad_row_seen;
    wire setup     = psel && !penable;
    wire wr_access = psel && penable && pwrite;
    wire [11:0] row_off = paddr - MWSD_A_ROW0;
    wire hit_ctrl  = paddr == MWSD_A_CTRL;
    wire hit_sc    = paddr == MWSD_A_SHORTCUT;
    wire hit_st    = paddr == MWSD_A_STATUS;
    wire hit_row   = paddr >= MWSD_A_ROW0 && row_off[1:0] == 2'h0
                     && row_off < 12'(MWSD_ROWS) * MWSD_A_ROWSTEP;
    wire [2:0] rd_row = 3'(row_off >> 2);
    wire [ROW_W-1:0] rd_r = rows[int'(rd_row)*ROW_W +: ROW_W];
    wire mapped    = hit_ctrl || hit_sc || hit_st || hit_row;
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (hit_ctrl) begin
            next_rdata[0] = decode_enable;
        end else if (hit_sc) begin
            next_rdata[MWSD_CSEL_W-1:0]           = measure_block_select;
            next_rdata[MWSD_SC_RT1_LO +: MWSD_RT_W] = output_route_first;
            next_rdata[MWSD_SC_RT2_LO +: MWSD_RT_W] = output_route_second;
            next_rdata[MWSD_SC_RT3_LO +: MWSD_RT_W] = output_route_third;
        end else if (hit_st) begin
            next_rdata[0]                  = state != MWSD_IDLE;
            next_rdata[MWSD_ST_ROW_LO +: 3] = jump_row;
            next_rdata[MWSD_ST_BAD_BIT]    = bad_row_seen;
        end else if (hit_row) begin
            next_rdata[MWSD_COND_W-1:0]             = rd_r[MWSD_COND_W-1:0];
            next_rdata[MWSD_ROW_DEST_LO +: ADDR_W]  = rd_r[MWSD_COND_W +: ADDR_W];
            next_rdata[MWSD_ROW_VLD_BIT]            = rd_r[ROW_W-1];
        end
    end
    assign pready = 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata        <= '0;
            pslverr       <= 1'b0;
            decode_enable <= MWSD_CTRL_RST;
            bad_row_seen  <= 1'b0;
        end else begin
            if (setup) begin
                prdata  <= pwrite ? 32'h0 : next_rdata;
                pslverr <= !mapped;
            end
            if (wr_access && hit_ctrl && pstrb[0]) begin
                decode_enable <= pwdata[0];
            end
            // an ignored row code arriving with the clear still sets the flag
            if (bad_row) begin
                bad_row_seen <= 1'b1;
            end else if (wr_access && hit_st && pstrb[0] && pwdata[MWSD_ST_BAD_BIT]) begin
                bad_row_seen <= 1'b0;
            end
        end
    end

    a_row_dest_store: assert property (@(posedge pclk) disable iff (!presetn)
        row_wr && row_sel == 3'h0 |=> rows[MWSD_COND_W +: ADDR_W] == $past(next_dest)
            && rows[ROW_W-1])
        else $error("wait row dest not stored");
    a_bad_row_keep: assert property (@(posedge pclk) disable iff (!presetn)
        bad_row && !row_wr |=> rows == $past(rows))
        else $error("undefined row code changed the table");
    a_out_route_load: assert property (@(posedge pclk) disable iff (!presetn)
        accept && is_outsc |=> output_route_second == $past(instr_word[9:6])
            && output_route_third == $past(instr_word[5:2]))
        else $error("output shortcut not loaded");
    a_cur_sel_load: assert property (@(posedge pclk) disable iff (!presetn)
        accept && is_cursc && !is_outsc |=> measure_block_select == $past(instr_word[1:0]))
        else $error("current shortcut not loaded");
    a_jump_dest: assert property (@(posedge pclk) disable iff (!presetn)
        fire |=> jump_taken && jump_target == $past(hit_dest) ##1 !jump_taken)
        else $error("jump pulse or target wrong");
    a_gate_route: assert property (@(posedge pclk) disable iff (!presetn)
        output_route_first == 4'h5 && drive_logical[0] |=> low_side_gate_pin[0])
        else $error("first route not driving its gate");
    a_undef_feedback: assert property (@(posedge pclk) disable iff (!presetn)
        output_route_third >= MWSD_RT_UNDEF |-> !sc_vds[2] && !sc_src[2])
        else $error("undefined shortcut gives feedback");
    a_own_current: assert property (@(posedge pclk) disable iff (!presetn)
        measure_block_select == 2'h3 |-> cond_vec[63] != current_fb[3])
        else $error("own current feedback mis-selected");
    a_row_cond_store: assert property (@(posedge pclk) disable iff (!presetn)
        row_wr && row_sel == MWSD_ROW_LAST
        |=> rows[MWSD_ROW_LAST*ROW_W +: MWSD_COND_W] == $past(instr_word[MWSD_COND_W-1:0]))
        else $error("last wait row condition not stored");
    a_first_route_load: assert property (@(posedge pclk) disable iff (!presetn)
        accept && is_outsc
        |=> output_route_first == $past(instr_word[MWSD_RT1_LO +: MWSD_RT_W]))
        else $error("first output shortcut not loaded");
    a_undef_no_gate: assert property (@(posedge pclk) disable iff (!presetn)
        output_route_first >= MWSD_RT_UNDEF && drive_logical[2:1] == 2'h0
        |=> {low_side_gate_pin, high_side_gate_pin} == '0)
        else $error("undefined shortcut drives a gate");
endmodule : mwsd_decoder

// [mwsd_fetch_model.sv]
// mwsd_fetch_model: instruction fetch stand-in that feeds code words to the decoder
// assumes the bench pushes words; slow leaves an idle cycle between words
`timescale 1ns/1ns
module mwsd_fetch_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    output logic             instr_valid,
    output logic [15:0]      instr_word,
    output logic [9:0]       instr_addr
);
    logic [25:0] q[$];
    logic        gap;
    task automatic push(input logic [15:0] w, input logic [9:0] a);
        q.push_back({a, w});
    endtask : push
    // one word per valid cycle; an idle bus shows the inverse so a stale word is never reused
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_valid <= 1'b0;
            instr_word  <= 16'h0000;
            instr_addr  <= 10'h000;
            gap         <= 1'b0;
        end else if (q.size() != 0 && !(slow && gap)) begin
            {instr_addr, instr_word} <= q.pop_front();
            instr_valid <= 1'b1;
            gap         <= 1'b1;
        end else begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
            instr_addr  <= ~instr_addr;
            gap         <= 1'b0;
        end
    end
endmodule : mwsd_fetch_model

// [microcore_wait_and_shortcut_decode_tb_top.sv]
// testbench: drives code words, apb and condition inputs into one decoder core
// assumes core 0 defaults and a 10-bit code address
`timescale 1ns/1ns
module microcore_wait_and_shortcut_decode_tb_top;
    import mwsd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
    logic        instr_valid, wait_active, jump_taken, start_level, alu_done, boost;
    logic [11:0] paddr, vds, src;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, tcnt, rt1, rt2, rt3, rta [3];
    logic [15:0] instr_word, flags;
    logic [9:0]  instr_addr, jump_target, a;
    logic [2:0]  jump_row, drv;
    logic [4:0]  row_en, hs, ofs, hs_exp;
    logic [6:0]  ls, ls_exp;
    logic [5:0]  cur_fb;
    logic [1:0]  mbs, csel;
    logic [31:0] rows_exp [5];
    logic [12:0] jq[$];
    int          seed, n_mismatch, comparisons, c, r, k;

    mwsd_decoder #(.CORE_ID(0), .ADDR_W(10)) mwsd_decoder_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_addr(instr_addr), .wait_active(wait_active), .wait_row_enable(row_en),
        .jump_taken(jump_taken), .jump_target(jump_target), .jump_row(jump_row),
        .flags(flags), .terminal_count(tcnt), .start_level(start_level), .alu_done(alu_done),
        .boost_voltage_level(boost), .current_fb(cur_fb), .gate_vds_fb(vds), .gate_src_fb(src),
        .drive_logical(drv), .high_side_gate_pin(hs), .low_side_gate_pin(ls),
        .measure_block_select(mbs), .output_route_first(rt1), .output_route_second(rt2),
        .output_route_third(rt3));
    mwsd_fetch_model mwsd_fetch_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr));

    always #4 pclk = ~pclk;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // zero wait states are not assumed: the access phase lasts until pready
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic run(input logic [15:0] w, input logic [9:0] ad);
        mwsd_fetch_model_i.push(w, ad);
        while (mwsd_fetch_model_i.q.size() != 0) @(posedge pclk);
        tick(3);
    endtask : run
    function automatic logic fb(input logic [11:0] v, input logic [3:0] code);
        return (code < 4'hc) ? v[code] : 1'b0;
    endfunction : fb
    function automatic logic cond_val(input int cc);
        if (cc < 16) return !flags[cc];
        if (cc < 32) return flags[cc-16];
        if (cc < 36) return tcnt[cc-32];
        if (cc < 38) return start_level == (cc == 37);
        if (cc < 41) return !fb(vds, rta[cc-38]);
        if (cc < 44) return !fb(src, rta[cc-41]);
        if (cc < 47) return fb(vds, rta[cc-44]);
        if (cc == 47) return alu_done;
        if (cc < 50) return boost == (cc == 48);
        if (cc < 56) return cur_fb[cc-50];
        if (cc < 62) return !cur_fb[cc-56];
        return cur_fb[csel] == (cc == 62);
    endfunction : cond_val

    // a jump pulse takes the oldest noted jump off the queue
    always @(posedge pclk) begin
        if (presetn === 1'b1 && jump_taken === 1'b1) begin
            if (jq.size() == 0) check(32'h1, 32'h0, "unexpected jump");
            else check({jump_row, jump_target}, jq.pop_front(), "jump");
        end
    end
    initial begin
        #200000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        seed = 90657;
        {pclk, presetn, psel, penable, pwrite, slow, wait_active, start_level, alu_done} = '0;
        {boost, paddr, pwdata, flags, tcnt, cur_fb, vds, src, drv, row_en} = '0;
        pstrb = 4'hf;
        foreach (rows_exp[i]) rows_exp[i] = 32'h0;
        tick(10);
        presetn <= 1'b1;
        tick(2);
        check({mbs, rt1, rt2, rt3}, {2'h0, 4'h0, 4'h5, 4'h9}, "reset shortcuts");
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0000_9500, "shortcut register");
        apb(1'b0, 12'h0fc, 32'h0);
        check(rd, 32'h0, "unmapped read data");
        check(err, 1'b1, "unmapped read error");
        $display("test reset done");
        for (k = 3; k >= 0; k--) begin
            run(16'h3578 | k[15:0], 10'h011);
            check(mbs, k[1:0], "current select");
        end
        csel = 2'h0;
        run(16'h357f, 10'h012);
        check(mbs, csel, "bad current word");
        apb(1'b1, 12'h000, 32'h0);
        run(16'h357b, 10'h013);
        check(mbs, csel, "decode disabled");
        apb(1'b1, 12'h000, 32'h1);
        $display("test current shortcut done");
        for (k = 0; k < 8; k++) begin
            foreach (rta[i]) rta[i] = 4'($unsigned($random(seed)) % 13);
            if (k == 0) rta[0] = 4'h5;
            run({2'b10, rta[0], rta[1], rta[2], 2'b11}, 10'h020);
            check({rt1, rt2, rt3}, {rta[0], rta[1], rta[2]}, "output routes");
            run({2'b10, ~rta[0], rta[1], rta[2], 2'b01}, 10'h021);
            check({rt1, rt2, rt3}, {rta[0], rta[1], rta[2]}, "bad tail");
            drv <= 3'($random(seed)) | {2'b00, k == 0};
            tick(2);
            {hs_exp, ls_exp} = '0;
            for (int i = 0; i < 3; i++) begin
                if (drv[i] && rta[i] < 5) hs_exp[rta[i]] = 1'b1;
                else if (drv[i] && rta[i] < 12) ls_exp[rta[i]-5] = 1'b1;
            end
            check({hs, ls}, {hs_exp, ls_exp}, "gate pins");
        end
        $display("test output shortcut done");
        for (c = 0; c < 64; c++) begin
            r = $unsigned($random(seed)) % 5;
            ofs = 5'($random(seed));
            a = 10'($random(seed));
            slow <= c[0];
            {flags, tcnt, start_level, alu_done, boost} <= 23'($random(seed));
            {cur_fb, vds, src} <= 30'($random(seed));
            run({2'b11, ofs, r[2:0], c[5:0]}, a);
            rows_exp[r] = {1'b1, 5'h00, a + {{5{ofs[4]}}, ofs}, 10'h000, c[5:0]};
            if (cond_val(c)) jq.push_back({r[2:0], a + {{5{ofs[4]}}, ofs}});
            row_en <= 5'h01 << r;
            wait_active <= 1'b1;
            tick(4);
            wait_active <= 1'b0;
            tick(2);
        end
        check(jq.size(), 0, "missing jumps");
        $display("test wait entries done");
        for (k = 5; k < 8; k++) run({2'b11, 5'h01, k[2:0], 6'h25}, 10'h030);
        apb(1'b0, 12'h008, 32'h0);
        check(rd[4], 1'b1, "bad row flag");
        for (k = 0; k < 5; k++) begin
            apb(1'b0, 12'h010 + 12'(4 * k), 32'h0);
            check(rd, rows_exp[k], "row contents");
        end
        apb(1'b1, 12'h008, 32'h10);
        apb(1'b0, 12'h008, 32'h0);
        check(rd[4], 1'b0, "bad row flag cleared");
        $display("test row codes done");
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(2);
        check({mbs, rt1, rt2, rt3}, {2'h0, 4'h0, 4'h5, 4'h9}, "shortcuts after reset");
        apb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0, "row after reset");
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : microcore_wait_and_shortcut_decode_tb_top
